//--- src/pd_ctl_pkg.sv
// Constants, opcodes and carrier types for the power-state command logic.
// Assumes a 100 MHz reference clock and a serial clock from the host.
package pd_ctl_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_DEEP_DOWN = 8'hB9;
  localparam logic [7:0] OP_RELEASE = 8'hAB;
  localparam logic [7:0] OP_RST_ENABLE = 8'h66;
  localparam logic [7:0] OP_RST_DO = 8'h99;
  localparam logic [7:0] OP_RST_ALT = 8'hFF;
  // Status read opcode; value arbitrary, used only by checks
  localparam logic [7:0] OP_STATUS_RD = 8'h0F;

  // ----------------------------------------------------------------
  // Framing and timing
  // ----------------------------------------------------------------
  localparam logic [3:0] BITS_PER_OP = 4'h8;
  localparam logic [3:0] BITS_OVER = 4'h9;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ENTRY_DELAY_NS = 3000;
  localparam int RELEASE_DELAY_NS = 1500000;
  // Longest times round down
  localparam int ENTRY_CYC = ENTRY_DELAY_NS / CLK_PERIOD_NS;
  localparam int RELEASE_CYC = RELEASE_DELAY_NS / CLK_PERIOD_NS;
  // Cycles from chip select rising to the state change: sync, settle,
  // load and the exit edge once the timer has run out
  localparam logic [1:0] SETTLE_CYC = 2'h2;
  localparam int EVAL_LAT = 6;
  localparam int TIMER_W = 18;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_STANDBY = 2'b00,
    PWR_ENTER = 2'b01,
    PWR_DOWN = 2'b10,
    PWR_RELEASE = 2'b11
  } pwr_e;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
  } cmd_s;

endpackage

//--- src/bit_sync.sv
// Two-flop level synchroniser into the reference clock domain.
// Assumes the input is a level that holds for at least two clock periods.
`timescale 1ns/1ps
module bit_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_async,
  output logic o_sync
);

  typedef struct packed {
    logic s1;
    logic s2;
  } sync_s;

  sync_s r;
  sync_s nxt;

  always_comb begin
    nxt.s1 = i_async;
    nxt.s2 = r.s1;
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r <= {RST_VAL, RST_VAL};
    end else begin
      r <= nxt;
    end
  end

  assign o_sync = r.s2;

endmodule

//--- src/op_shifter.sv
// Serial-clock side: shifts opcode bits in and reports byte and overrun events.
// Assumes the serial clock stands still while chip select is high.
`timescale 1ns/1ps
module op_shifter (
  input wire logic i_sclk,
  input wire logic i_nrst,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  output logic [7:0] o_byte,
  output logic o_byte_tgl,
  output logic o_over_tgl
);

  typedef struct packed {
    logic [3:0] cnt;
    logic [7:0] sh;
  } frame_s;

  typedef struct packed {
    logic [7:0] byte_q;
    logic byte_tgl;
    logic over_tgl;
  } res_s;

  frame_s fr_r;
  frame_s fr_nxt;
  res_s res_r;
  res_s res_nxt;
  logic frame_rst_n;

  // Bit count restarts whenever chip select is high, no sclk edge needed
  assign frame_rst_n = i_nrst & ~i_cs_n;

  localparam logic [3:0] BITS_LAST_L = pd_ctl_pkg::BITS_PER_OP - 4'h1;
  localparam logic [3:0] BITS_OVER_L = pd_ctl_pkg::BITS_OVER;

  always_comb begin
    fr_nxt = fr_r;
    res_nxt = res_r;
    fr_nxt.sh = {fr_r.sh[6:0], i_mosi};
    if (fr_r.cnt != BITS_OVER_L) begin
      fr_nxt.cnt = fr_r.cnt + 4'h1;
    end
    if (fr_r.cnt == BITS_LAST_L) begin
      res_nxt.byte_q = {fr_r.sh[6:0], i_mosi};
      res_nxt.byte_tgl = ~res_r.byte_tgl;
    end
    if (fr_r.cnt == pd_ctl_pkg::BITS_PER_OP) begin
      res_nxt.over_tgl = ~res_r.over_tgl;
    end
  end

  always_ff @(posedge i_sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fr_r <= '0;
    end else begin
      fr_r <= fr_nxt;
    end
  end

  // Results survive chip select so the reference side can read them
  always_ff @(posedge i_sclk or negedge i_nrst) begin
    if (!i_nrst) begin
      res_r <= '0;
    end else begin
      res_r <= res_nxt;
    end
  end

  assign o_byte = res_r.byte_q;
  assign o_byte_tgl = res_r.byte_tgl;
  assign o_over_tgl = res_r.over_tgl;

  // First bit of the frame must have reached bit 6, one below the top of the shifter
  property p_msb_first;
    @(posedge i_sclk) disable iff (!i_nrst || i_cs_n)
    (fr_r.cnt == BITS_LAST_L) |-> (fr_r.sh[6] == $past(i_mosi, 7)) && (fr_r.sh[0] == $past(i_mosi));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("opcode not shifted msb first");

endmodule

//--- src/pd_ctl.sv
// Deep power-down command handling for a serial flash device.
// Assumes a host that drives chip select, serial clock and data in,
// keeps chip select high for at least three reference clocks between frames.
// Functional notes
// - Opcode B9h requests deep power-down.
// - Chip select must rise at byte boundary.
// - Enter power-down within entry delay.
// - Asleep, only release and reset opcodes work.
// - Status read ignored while powered down.
// - Power-up always lands in standby.
// - Opcode ABh framed by chip select releases.
// - Commands accepted only after release delay.
// - Entry delay at most 3 microseconds.
// - Release delay at most 1.5 milliseconds.
`timescale 1ns/1ps
module pd_ctl #(
  parameter int REL_CYC = pd_ctl_pkg::RELEASE_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  output pd_ctl_pkg::cmd_s o_cmd,
  output logic o_rst_req,
  output logic o_sleep,
  output logic o_ready
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pd_ctl_pkg::pwr_e pwr;
    logic [pd_ctl_pkg::TIMER_W-1:0] timer;
    logic cs_prev;
    logic byte_prev;
    logic over_prev;
    logic byte_seen;
    logic over;
    logic [7:0] opcode;
    logic rst_armed;
    logic [1:0] settle;
    pd_ctl_pkg::cmd_s cmd;
    logic rst_pulse;
  } ctl_s;

  localparam logic [pd_ctl_pkg::TIMER_W-1:0] ENTRY_LOAD =
    pd_ctl_pkg::TIMER_W'(pd_ctl_pkg::ENTRY_CYC - pd_ctl_pkg::EVAL_LAT);
  localparam logic [pd_ctl_pkg::TIMER_W-1:0] REL_LOAD =
    pd_ctl_pkg::TIMER_W'(REL_CYC - pd_ctl_pkg::EVAL_LAT);

  ctl_s r;
  ctl_s nxt;

  logic [7:0] link_byte;
  logic byte_tgl_a;
  logic over_tgl_a;
  logic cs_s;
  logic byte_tgl_s;
  logic over_tgl_s;

  // ----------------------------------------------------------------
  // Link side and crossings
  // ----------------------------------------------------------------
  op_shifter u_shift (
    .i_sclk(i_sclk),
    .i_nrst(i_nrst),
    .i_cs_n(i_cs_n),
    .i_mosi(i_mosi),
    .o_byte(link_byte),
    .o_byte_tgl(byte_tgl_a),
    .o_over_tgl(over_tgl_a)
  );

  bit_sync #(.RST_VAL(1'b1)) u_cs_sync (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_async(i_cs_n),
    .o_sync(cs_s)
  );

  bit_sync #(.RST_VAL(1'b0)) u_byte_sync (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_async(byte_tgl_a),
    .o_sync(byte_tgl_s)
  );

  bit_sync #(.RST_VAL(1'b0)) u_over_sync (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_async(over_tgl_a),
    .o_sync(over_tgl_s)
  );

  // ----------------------------------------------------------------
  // Frame decode helpers
  // ----------------------------------------------------------------
  function automatic logic op_is(input logic [7:0] op, input logic [7:0] code);
    op_is = (op == code);
  endfunction

  logic cs_rise;
  logic cs_fall;
  logic byte_ev;
  logic over_ev;
  logic exec_now;
  logic frame_ok;
  logic rst_hit;
  logic rel_hit;
  logic dpd_hit;

  always_comb begin
    cs_rise = cs_s & ~r.cs_prev;
    cs_fall = ~cs_s & r.cs_prev;
    byte_ev = byte_tgl_s ^ r.byte_prev;
    over_ev = over_tgl_s ^ r.over_prev;
    // Settle lets the last byte event land after chip select is seen high
    exec_now = (r.settle == 2'h1) || ((r.settle != 2'h0) && cs_fall);
    frame_ok = r.byte_seen & ~r.over;
    dpd_hit = frame_ok & op_is(r.opcode, pd_ctl_pkg::OP_DEEP_DOWN);
    rel_hit = frame_ok & op_is(r.opcode, pd_ctl_pkg::OP_RELEASE);
    rst_hit = frame_ok & (op_is(r.opcode, pd_ctl_pkg::OP_RST_ALT) |
              (r.rst_armed & op_is(r.opcode, pd_ctl_pkg::OP_RST_DO)));
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt = r;
    nxt.cmd.valid = 1'b0;
    nxt.rst_pulse = 1'b0;
    nxt.cs_prev = cs_s;
    nxt.byte_prev = byte_tgl_s;
    nxt.over_prev = over_tgl_s;

    if (byte_ev) begin
      // Link byte is stable: it only changes at the next frame's eighth bit
      nxt.byte_seen = 1'b1;
      nxt.opcode = link_byte;
      if (r.pwr == pd_ctl_pkg::PWR_STANDBY) begin
        nxt.cmd.valid = 1'b1;
        nxt.cmd.opcode = link_byte;
      end
    end
    if (over_ev) begin
      nxt.over = 1'b1;
    end

    if (cs_rise) begin
      nxt.settle = pd_ctl_pkg::SETTLE_CYC;
    end else if (r.settle != 2'h0) begin
      nxt.settle = r.settle - 2'h1;
    end
    if (cs_fall) begin
      // A byte event in the same cycle still counts: set wins
      nxt.settle = 2'h0;
      nxt.byte_seen = byte_ev;
      nxt.over = over_ev;
    end

    if (exec_now && r.pwr != pd_ctl_pkg::PWR_RELEASE) begin
      nxt.rst_armed = frame_ok & op_is(r.opcode, pd_ctl_pkg::OP_RST_ENABLE);
    end

    if (r.timer != '0) begin
      nxt.timer = r.timer - 1'b1;
    end

    case (r.pwr)
      pd_ctl_pkg::PWR_STANDBY: begin
        if (exec_now && rst_hit) begin
          nxt.rst_pulse = 1'b1;
        end else if (exec_now && dpd_hit) begin
          nxt.pwr = pd_ctl_pkg::PWR_ENTER;
          nxt.timer = ENTRY_LOAD;
        end
      end
      pd_ctl_pkg::PWR_ENTER,
      pd_ctl_pkg::PWR_DOWN: begin
        // Only reset frames are recognised here, and release frames too in PWR_DOWN
        if (exec_now && rst_hit) begin
          nxt.pwr = pd_ctl_pkg::PWR_STANDBY;
          nxt.timer = '0;
          nxt.rst_pulse = 1'b1;
        end else if (r.pwr == pd_ctl_pkg::PWR_DOWN && exec_now && rel_hit) begin
          nxt.pwr = pd_ctl_pkg::PWR_RELEASE;
          nxt.timer = REL_LOAD;
        end else if (r.pwr == pd_ctl_pkg::PWR_ENTER && r.timer == '0) begin
          nxt.pwr = pd_ctl_pkg::PWR_DOWN;
        end
      end
      pd_ctl_pkg::PWR_RELEASE: begin
        // Frames sent now are dropped; host must hold chip select high
        if (r.timer == '0) begin
          nxt.pwr = pd_ctl_pkg::PWR_STANDBY;
        end
      end
      default: begin
        nxt.pwr = pd_ctl_pkg::PWR_STANDBY;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r <= '{pwr: pd_ctl_pkg::PWR_STANDBY, cs_prev: 1'b1, default: '0};
    end else begin
      r <= nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_cmd = r.cmd;
  assign o_rst_req = r.rst_pulse;
  assign o_sleep = (r.pwr == pd_ctl_pkg::PWR_DOWN);
  assign o_ready = (r.pwr == pd_ctl_pkg::PWR_STANDBY);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Exec is sampled EVAL_LAT - 1 edges after chip select rises
  localparam int A_ENTRY_MAX = pd_ctl_pkg::ENTRY_CYC - pd_ctl_pkg::EVAL_LAT + 2;
  logic boot_done_r;
  logic [pd_ctl_pkg::TIMER_W-1:0] rel_cnt_r;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      boot_done_r <= 1'b0;
      rel_cnt_r <= '0;
    end else begin
      boot_done_r <= 1'b1;
      rel_cnt_r <= (r.pwr == pd_ctl_pkg::PWR_RELEASE) ? rel_cnt_r + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_dpd_exec;
    exec_now && dpd_hit && !rst_hit && r.pwr == pd_ctl_pkg::PWR_STANDBY;
  endsequence

  sequence s_rel_exec;
    exec_now && rel_hit && !rst_hit && r.pwr == pd_ctl_pkg::PWR_DOWN;
  endsequence

  property p_dpd_start;
    s_dpd_exec |=> (r.pwr == pd_ctl_pkg::PWR_ENTER) [*8];
  endproperty
  a_dpd_start: assert property (p_dpd_start) else $error("power-down not started");

  property p_dpd_bound;
    s_dpd_exec |-> ##[1:A_ENTRY_MAX] (r.pwr == pd_ctl_pkg::PWR_DOWN);
  endproperty
  a_dpd_bound: assert property (p_dpd_bound) else $error("power-down entry too slow");

  property p_over_discard;
    exec_now && r.over && r.pwr == pd_ctl_pkg::PWR_STANDBY |=> r.pwr == pd_ctl_pkg::PWR_STANDBY;
  endproperty
  a_over_discard: assert property (p_over_discard) else $error("overlong frame acted on");

  property p_down_filter;
    r.pwr == pd_ctl_pkg::PWR_DOWN && exec_now && !rel_hit && !rst_hit |=> r.pwr == pd_ctl_pkg::PWR_DOWN;
  endproperty
  a_down_filter: assert property (p_down_filter) else $error("sleep left on wrong opcode");

  property p_status_ignored;
    byte_ev && link_byte == pd_ctl_pkg::OP_STATUS_RD && r.pwr != pd_ctl_pkg::PWR_STANDBY |=> !o_cmd.valid;
  endproperty
  a_status_ignored: assert property (p_status_ignored) else $error("status read passed asleep");

  property p_boot_standby;
    !boot_done_r |-> o_ready && !o_sleep;
  endproperty
  a_boot_standby: assert property (p_boot_standby) else $error("not standby after reset");

  property p_rel_start;
    s_rel_exec |=> (r.pwr == pd_ctl_pkg::PWR_RELEASE) [*8];
  endproperty
  a_rel_start: assert property (p_rel_start) else $error("release not started");

  property p_rel_quiet;
    r.pwr == pd_ctl_pkg::PWR_RELEASE |=> !o_cmd.valid && !o_rst_req;
  endproperty
  a_rel_quiet: assert property (p_rel_quiet) else $error("command during release");

  property p_rel_bound;
    r.pwr == pd_ctl_pkg::PWR_RELEASE |-> rel_cnt_r < pd_ctl_pkg::TIMER_W'(REL_CYC);
  endproperty
  a_rel_bound: assert property (p_rel_bound) else $error("release delay exceeded");

endmodule

//--- sim/host_model.sv
// Host controller model that frames opcode bytes onto the serial link.
// Assumes the bench calls send only while chip select is high.
`timescale 1ns/1ps
module host_model (
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_mosi
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_mosi = 1'b0;
  end

  // Serial clock runs only inside frames; extra bits break the byte boundary
  task automatic send(input logic [7:0] op, input int extra);
    logic [15:0] sr;
    sr = {op, 8'hFF};
    o_cs_n = 1'b0;
    #4;
    for (int i = 0; i < 8 + extra; i++) begin
      o_mosi = sr[15 - i];
      #3 o_sclk = 1'b1;
      #3 o_sclk = 1'b0;
    end
    // Rises 1 ns past a reference edge (7 ns with one extra bit) so the synchroniser never races the pin
    #4 o_cs_n = 1'b1;
    // Released data line must not keep showing the last bit
    o_mosi = ~o_mosi;
  endtask
endmodule

//--- sim/tb.sv
// Self-checking bench for the deep power-down command logic.
// Assumes the host model drives the link and chip select stays high between frames.
`timescale 1ns/1ps
module tb;
  // Short release count keeps the run brief
  localparam int REL = 64;
  logic i_ref_clk;
  logic i_nrst;
  logic cs_n;
  logic sclk;
  logic mosi;
  pd_ctl_pkg::cmd_s o_cmd;
  logic o_rst_req;
  logic o_sleep;
  logic o_ready;
  logic [7:0] last_op;
  int failures = 0;
  int checked = 0;
  int cmd_cnt = 0;
  int rst_cnt = 0;

  host_model u_host_model (.o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));
  pd_ctl #(.REL_CYC(REL)) u_pd_ctl (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_mosi(mosi), .o_cmd(o_cmd), .o_rst_req(o_rst_req), .o_sleep(o_sleep), .o_ready(o_ready));

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  // One-cycle pulses are counted mid-cycle, where they stand
  always @(negedge i_ref_clk) begin
    if (o_cmd.valid === 1'b1) begin
      cmd_cnt++;
      last_op = o_cmd.opcode;
    end
    if (o_rst_req === 1'b1) begin
      rst_cnt++;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // Cycles until a flag reads 1: sel 0 asleep, 1 awake, 2 ready
  task automatic wait_flag(input int sel, input int bound, output int n);
    logic f;
    n = 0;
    f = 1'b0;
    while (f !== 1'b1) begin
      @(negedge i_ref_clk);
      n++;
      f = (sel == 0) ? o_sleep : (sel == 1) ? !o_sleep : o_ready;
      if (n > bound) begin
        failures++;
        $display("[FAIL] wait_flag %0d expected set seen timeout", sel);
        finish_test();
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_idle();
    chk("sleep", 9'h000, o_sleep);
    chk("ready", 9'h001, o_ready);
    chk("cmd", 9'h000, o_cmd);
    $display("t_idle done");
  endtask

  task automatic t_forward();
    int c;
    c = cmd_cnt;
    u_host_model.send(pd_ctl_pkg::OP_STATUS_RD, 0);
    repeat (8) @(negedge i_ref_clk);
    chk("cmd_count", 9'(c + 1), 9'(cmd_cnt));
    chk("cmd_opcode", {1'b0, pd_ctl_pkg::OP_STATUS_RD}, {1'b0, last_op});
    $display("t_forward done");
  endtask

  task automatic t_long_frame();
    u_host_model.send(pd_ctl_pkg::OP_DEEP_DOWN, 1);
    repeat (pd_ctl_pkg::ENTRY_CYC + 20) @(negedge i_ref_clk);
    chk("sleep", 9'h000, o_sleep);
    chk("ready", 9'h001, o_ready);
    $display("t_long_frame done");
  endtask

  task automatic t_enter();
    int n;
    u_host_model.send(pd_ctl_pkg::OP_DEEP_DOWN, 0);
    wait_flag(0, pd_ctl_pkg::ENTRY_CYC + 1, n);
    chk("sleep", 9'h001, o_sleep);
    chk("ready", 9'h000, o_ready);
    $display("t_enter done after %0d cycles", n);
  endtask

  task automatic t_ignore();
    logic [7:0] ops [5];
    int ext [5];
    int c;
    int r;
    ops = '{pd_ctl_pkg::OP_STATUS_RD, pd_ctl_pkg::OP_DEEP_DOWN, pd_ctl_pkg::OP_RST_DO, 8'h9F,
      pd_ctl_pkg::OP_RELEASE};
    ext = '{0, 0, 0, 0, 1};
    c = cmd_cnt;
    r = rst_cnt;
    for (int i = 0; i < 5; i++) begin
      u_host_model.send(ops[i], ext[i]);
      repeat (8) @(negedge i_ref_clk);
    end
    chk("cmd_count", 9'(c), 9'(cmd_cnt));
    chk("rst_count", 9'(r), 9'(rst_cnt));
    chk("sleep", 9'h001, o_sleep);
    $display("t_ignore done");
  endtask

  task automatic t_wake_reset(input logic [7:0] first);
    int r;
    r = rst_cnt;
    u_host_model.send(first, 0);
    repeat (8) @(negedge i_ref_clk);
    if (first == pd_ctl_pkg::OP_RST_ENABLE) begin
      chk("sleep_armed", 9'h001, o_sleep);
      u_host_model.send(pd_ctl_pkg::OP_RST_DO, 0);
      repeat (8) @(negedge i_ref_clk);
    end
    chk("rst_count", 9'(r + 1), 9'(rst_cnt));
    chk("sleep", 9'h000, o_sleep);
    chk("ready", 9'h001, o_ready);
    $display("t_wake_reset %0h done", first);
  endtask

  task automatic t_release();
    int n;
    int m;
    u_host_model.send(pd_ctl_pkg::OP_RELEASE, 0);
    wait_flag(1, 8, n);
    // Chip select stays high for the whole release wait
    wait_flag(2, REL + 1 - n, m);
    chk("release_wait", 9'h001, 9'(n + m >= REL - 2));
    $display("t_release done after %0d cycles", n + m);
  endtask

  initial begin
    i_nrst = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    t_idle();
    i_nrst = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    // No write-type instruction is issued, so the power-up write wait never applies
    t_idle();
    t_forward();
    t_long_frame();
    t_wake_reset(pd_ctl_pkg::OP_RST_ALT);
    t_enter();
    t_ignore();
    t_wake_reset(pd_ctl_pkg::OP_RST_ALT);
    t_enter();
    t_wake_reset(pd_ctl_pkg::OP_RST_ENABLE);
    t_enter();
    t_release();
    t_forward();
    t_enter();
    i_nrst = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    t_idle();
    i_nrst = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    t_idle();
    t_forward();
    finish_test();
  end
endmodule
